/* rtl/eti_pkg.sv */
// Package: register map, field layout, reset values and types of the edge and timer interrupt unit
package eti_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] EDGE_SEL_IDX  = 8'hBF; // Edge select register
	localparam logic [7:0] IRQ_FLAG_IDX  = 8'hC8; // Request flag register
	localparam logic [7:0] IRQ_EN_IDX    = 8'hC9; // Source enable register
	localparam logic [7:0] STACK_IDX     = 8'hDF; // Global enable and stack pointer
	localparam logic [7:0] INT_STAT_IDX  = 8'hF0; // Sticky event status, write one to clear
	localparam logic [7:0] INT_MASK_IDX  = 8'hF1; // Event mask for the bus interrupt
	localparam logic [7:0] SAVE_VIEW_IDX = 8'hF2; // Save buffer contents, read only

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned EDGE_LSB     = 3; // Edge mode field is bits 4:3
	localparam int unsigned EDGE_MSB     = 4;
	localparam int unsigned EXT_BIT      = 0; // External pin source in flag and enable
	localparam int unsigned TMR_BIT      = 4; // Timer source in flag and enable
	localparam int unsigned GIE_BIT      = 7; // Global enable in stack register
	localparam int unsigned EV_EXT       = 0; // Status event: external edge
	localparam int unsigned EV_TMR       = 1; // Status event: timer overflow
	localparam int unsigned EV_VEC       = 2; // Status event: vector entry
	localparam int unsigned EV_W         = 3; // Number of status events
	localparam int unsigned TIMEOUT_BIT  = 4; // Timeout flag inside the status flags
	localparam int unsigned PWRDN_BIT    = 3; // Power-down flag inside the status flags

	// ----------------------------------------------------------------
	// Reset values and constants
	// ----------------------------------------------------------------
	localparam logic [1:0]  EDGE_RST     = 2'h2;  // Falling edge after reset
	localparam logic [1:0]  STACK_POINTER_REG_RST     = 2'h3;  // Stack pointer after reset
	localparam logic [7:0]  FLAGS_KEEP   = 8'h18; // Flag bits a restore leaves alone
	localparam logic [11:0] VEC_ADDR     = 12'h008; // Shared interrupt vector

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		EDGE_RSVD = 2'h0,
		EDGE_RISE = 2'h1,
		EDGE_FALL = 2'h2,
		EDGE_BOTH = 2'h3
	} eti_edge_t;

	typedef enum logic [1:0] {
		SVC_IDLE   = 2'h0,
		SVC_ACTIVE = 2'h1
	} eti_svc_t;

	// Accumulator and status flags travel together
	typedef struct packed {
		logic [7:0] acc;
		logic [7:0] flags;
	} eti_ctx_t;

endpackage : eti_pkg

/* rtl/eti_pin_edge.sv */
// Pin synchroniser and configurable edge detector for the external request pin
`timescale 1ns/100ps
`default_nettype none
module eti_pin_edge
	import eti_pkg::*;
(
	input  wire logic      hclk,       // Core clock
	input  wire logic      hresetn,    // Asynchronous reset, active low
	input  wire logic      pin,        // Raw external pin
	input  wire eti_edge_t mode,       // Selected trigger edge
	output logic           edge_hit,   // One-cycle pulse on a qualifying edge
	output logic           any_change  // One-cycle pulse on any settled change
);

	// ----------------------------------------------------------------
	// Synchroniser and settled level
	// ----------------------------------------------------------------
	logic sync1;   // First stage, read only by sync2
	logic sync2;   // Second stage
	logic sync3;   // Third stage
	logic settled; // Level accepted once stages two and three agree

	// Three stages; metastability is confined to sync1
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			sync3 <= 1'b0;
		end else begin
			sync1 <= pin;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// Previous accepted level, compared with the new one for edges
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			settled <= 1'b0;
		end else if (sync2 == sync3) begin
			settled <= sync3;
		end
	end

	// ----------------------------------------------------------------
	// Edge qualification
	// ----------------------------------------------------------------
	logic rise; // Settled low to high
	logic fall; // Settled high to low
	assign rise       = (sync2 == sync3) && sync3 && !settled;
	assign fall       = (sync2 == sync3) && !sync3 && settled;
	assign any_change = rise || fall;

	// Reserved mode never triggers
	always_comb begin
		unique case (mode)
			EDGE_RISE: edge_hit = rise;
			EDGE_FALL: edge_hit = fall;
			EDGE_BOTH: edge_hit = rise || fall;
			EDGE_RSVD: edge_hit = 1'b0;
		endcase
	end

endmodule : eti_pin_edge
`default_nettype wire

/* rtl/eti_unit.sv */
// Edge and timer interrupt unit: flags, enables, vectoring, wake latch, context buffer
//
// Functional notes
// - Configured pin edge always sets external flag
// - Enabled pin edge vectors core to 8
// - Enabled pin edge in power-down latched, serviced first
// - Bits 4:3 select reserved/rise/fall/both edge
// - Timer overflow always sets timer flag
// - Enabled timer overflow vectors; disabled only flags
// - Flag alone never vectors; enable required
// - One-level save buffer for accumulator, flags
// - Restore leaves timeout, power-down bits unchanged
// - Flags stay set until software clears
// - Vectoring needs global enable; entry clears, return sets
// - Flag register: bit 4 timer, bit 0 pin
// - Enable register: bit 0 pin, bit 4 timer
`timescale 1ns/100ps
`default_nettype none
module eti_unit
	import eti_pkg::*;
#(
	parameter int unsigned ADDR_W = 12 // Bus address width
)(
	input  wire logic              hclk,          // Core clock, 100 MHz
	input  wire logic              hresetn,       // Asynchronous reset, active low
	input  wire logic              hsel,          // AHB-Lite slave select
	input  wire logic [ADDR_W-1:0] haddr,         // Byte address
	input  wire logic [1:0]        htrans,        // Transfer type
	input  wire logic              hwrite,        // Write when high
	input  wire logic [2:0]        hsize,         // Transfer size
	input  wire logic              hready,        // Bus ready in
	input  wire logic [31:0]       hwdata,        // Write data
	output logic [31:0]            hrdata,        // Read data
	output logic                   hreadyout,     // Slave ready
	output logic                   hresp,         // Always OKAY
	input  wire logic              ext_pin,       // External request pin
	input  wire logic              timer_ovf,     // Timer overflow pulse
	input  wire logic              powerdown,     // Core is in power-down
	output logic                   wake_req,      // Pulse: wake the core
	output logic                   vector_req,    // Request to enter service
	input  wire logic              vector_ack,    // Core takes the vector
	output logic [11:0]            vector_addr,   // Vector address
	input  wire logic              return_from_interrupt_stb,      // Return from service
	input  wire logic              save_stb,      // Save instruction
	input  wire logic              restore_stb,   // Restore instruction
	input  wire eti_ctx_t          ctx_in,        // Live accumulator and flags
	output eti_ctx_t               ctx_out,       // Restored context
	output logic                   ctx_out_valid, // Pulse with ctx_out
	output logic                   irq            // Level interrupt to software
);

	// ----------------------------------------------------------------
	// AHB-Lite address phase capture
	// ----------------------------------------------------------------
	logic       ph_wr;   // Data phase of a write is in progress
	logic [7:0] ph_idx;  // Register index of that write
	logic       take;    // Address phase accepted this cycle
	logic [7:0] a_idx;   // Register index of the address phase

	assign take      = hsel && hready && htrans[1];
	assign a_idx     = haddr[9:2];
	assign hreadyout = 1'b1; // Zero wait states, every access completes at once
	assign hresp     = 1'b0;

	// Hold the write target until its data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_wr  <= 1'b0;
			ph_idx <= 8'h00;
		end else begin
			ph_wr  <= take && hwrite;
			ph_idx <= a_idx;
		end
	end

	// Write strobe for one register, decoded in several places
	function automatic logic wr_to(input logic [7:0] idx, input logic pw,
	                               input logic [7:0] pi);
		wr_to = pw && (pi == idx);
	endfunction : wr_to

	logic wr_edge;  // Edge select write
	logic wr_flag;  // Flag write
	logic wr_en;    // Enable write
	logic wr_stk;   // Stack register write
	logic wr_stat;  // Status clear write
	logic wr_mask;  // Mask write
	assign wr_edge = wr_to(EDGE_SEL_IDX, ph_wr, ph_idx);
	assign wr_flag = wr_to(IRQ_FLAG_IDX, ph_wr, ph_idx);
	assign wr_en   = wr_to(IRQ_EN_IDX,   ph_wr, ph_idx);
	assign wr_stk  = wr_to(STACK_IDX,    ph_wr, ph_idx);
	assign wr_stat = wr_to(INT_STAT_IDX, ph_wr, ph_idx);
	assign wr_mask = wr_to(INT_MASK_IDX, ph_wr, ph_idx);

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	eti_edge_t  ext_edge_mode;       // Selected pin edge
	logic       ext_pin_irq_enable;  // Pin source enable
	logic       timer_irq_enable;    // Timer source enable
	logic [1:0] stack_ptr;           // Stack pointer bits, plain storage
	logic [EV_W-1:0] int_mask;       // Event mask

	// Software-written settings
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_edge_mode      <= eti_edge_t'(EDGE_RST);
			ext_pin_irq_enable <= 1'b0;
			timer_irq_enable   <= 1'b0;
			stack_ptr          <= STACK_POINTER_REG_RST;
			int_mask           <= '0;
		end else begin
			if (wr_edge) begin
				ext_edge_mode <= eti_edge_t'(hwdata[EDGE_MSB:EDGE_LSB]);
			end
			if (wr_en) begin
				ext_pin_irq_enable <= hwdata[EXT_BIT];
				timer_irq_enable   <= hwdata[TMR_BIT];
			end
			if (wr_stk) begin
				stack_ptr <= hwdata[1:0];
			end
			if (wr_mask) begin
				int_mask <= hwdata[EV_W-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// External pin edge detection
	// ----------------------------------------------------------------
	logic ext_edge;   // Qualifying edge pulse
	logic pin_change; // Any settled change, used for wake-up

	eti_pin_edge u_pin_edge (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.pin        (ext_pin),
		.mode       (ext_edge_mode),
		.edge_hit   (ext_edge),
		.any_change (pin_change)
	);

	// Any settled change wakes the core; the pin source always wakes
	assign wake_req = powerdown && pin_change;

	// ----------------------------------------------------------------
	// Request flags
	// ----------------------------------------------------------------
	logic ext_pin_irq_flag; // Pin request flag
	logic timer_irq_flag;   // Timer request flag

	// Hardware set wins over a software clear in the same cycle;
	// entry to service leaves both flags alone
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_pin_irq_flag <= 1'b0;
			timer_irq_flag   <= 1'b0;
		end else begin
			ext_pin_irq_flag <= ext_edge ||
				(wr_flag ? hwdata[EXT_BIT] : ext_pin_irq_flag);
			timer_irq_flag   <= timer_ovf ||
				(wr_flag ? hwdata[TMR_BIT] : timer_irq_flag);
		end
	end

	// ----------------------------------------------------------------
	// Wake latch
	// ----------------------------------------------------------------
	logic wake_latch; // Edge seen while asleep, to be serviced first

	// Set by a matching enabled edge in power-down, dropped on entry
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wake_latch <= 1'b0;
		end else if (powerdown && ext_edge && ext_pin_irq_enable) begin
			wake_latch <= 1'b1;
		end else if (vector_req && vector_ack) begin
			wake_latch <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Global enable and service state
	// ----------------------------------------------------------------
	eti_svc_t svc;             // Service state
	logic     global_irq_enable;
	logic     pending;         // Enabled source waiting

	// Flag on its own is not enough; the enable must be set too
	assign pending = (ext_pin_irq_flag && ext_pin_irq_enable) ||
	                 (timer_irq_flag && timer_irq_enable) ||
	                 wake_latch;
	// No vectoring while asleep; the latched edge goes first on waking
	assign vector_req = global_irq_enable && (svc == SVC_IDLE) &&
	                    pending && !powerdown;

	// Entry and return tracking
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			svc <= SVC_IDLE;
		end else begin
			unique case (svc)
				SVC_IDLE: begin
					if (vector_req && vector_ack) begin
						svc <= SVC_ACTIVE;
					end
				end
				SVC_ACTIVE: begin
					if (return_from_interrupt_stb) begin
						svc <= SVC_IDLE;
					end
				end
				default: svc <= SVC_IDLE;
			endcase
		end
	end

	// Hardware entry and return take priority over a software write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			global_irq_enable <= 1'b0;
		end else if (vector_req && vector_ack) begin
			global_irq_enable <= 1'b0;
		end else if (return_from_interrupt_stb && svc == SVC_ACTIVE) begin
			global_irq_enable <= 1'b1;
		end else if (wr_stk) begin
			global_irq_enable <= hwdata[GIE_BIT];
		end
	end

	// Vector address held in a register for the fetch logic
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vector_addr <= 12'h000;
		end else begin
			vector_addr <= VEC_ADDR;
		end
	end

	// ----------------------------------------------------------------
	// Context save buffer
	// ----------------------------------------------------------------
	eti_ctx_t save_buf; // Single level; a second save overwrites the first

	// Only one level: no depth counter, no nesting
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			save_buf <= '0;
		end else if (save_stb) begin
			save_buf <= ctx_in;
		end
	end

	// Restore merges live timeout and power-down bits into the flags
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctx_out       <= '0;
			ctx_out_valid <= 1'b0;
		end else begin
			ctx_out_valid <= restore_stb;
			if (restore_stb) begin
				ctx_out.acc   <= save_buf.acc;
				ctx_out.flags <= (save_buf.flags & ~FLAGS_KEEP) |
				                 (ctx_in.flags & FLAGS_KEEP);
			end
		end
	end

	// ----------------------------------------------------------------
	// Event status and interrupt output
	// ----------------------------------------------------------------
	logic [EV_W-1:0] int_stat; // Sticky events
	logic [EV_W-1:0] events;   // This cycle's events

	always_comb begin
		events         = '0;
		events[EV_EXT] = ext_edge;
		events[EV_TMR] = timer_ovf;
		events[EV_VEC] = vector_req && vector_ack;
	end

	// Write one to clear; a new event in the clearing cycle survives
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			int_stat <= '0;
		end else begin
			int_stat <= events |
				(int_stat & ~(wr_stat ? hwdata[EV_W-1:0] : {EV_W{1'b0}}));
		end
	end

	assign irq = |(int_stat & int_mask);

	// ----------------------------------------------------------------
	// Read data, registered in the address phase
	// ----------------------------------------------------------------
	logic [31:0] next_rdata; // Read value for the next data phase

	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (a_idx)
			EDGE_SEL_IDX:  next_rdata[EDGE_MSB:EDGE_LSB] = ext_edge_mode;
			IRQ_FLAG_IDX: begin
				next_rdata[EXT_BIT] = ext_pin_irq_flag;
				next_rdata[TMR_BIT] = timer_irq_flag;
			end
			IRQ_EN_IDX: begin
				next_rdata[EXT_BIT] = ext_pin_irq_enable;
				next_rdata[TMR_BIT] = timer_irq_enable;
			end
			STACK_IDX: begin
				next_rdata[GIE_BIT] = global_irq_enable;
				next_rdata[1:0]     = stack_ptr;
			end
			INT_STAT_IDX:  next_rdata[EV_W-1:0] = int_stat;
			INT_MASK_IDX:  next_rdata[EV_W-1:0] = int_mask;
			SAVE_VIEW_IDX: next_rdata[15:0]     = save_buf;
			default:       next_rdata = 32'h0000_0000; // Unmapped reads zero
		endcase
	end

	// Reads take no side effects; capture only on an accepted read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (take && !hwrite) begin
			hrdata <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_ext_flag_set: assert property (ext_edge |=> ext_pin_irq_flag)
		else $error("pin edge did not set the pin flag");
	a_tmr_flag_set: assert property (timer_ovf |=> timer_irq_flag)
		else $error("overflow did not set the timer flag");
	a_tmr_vectors: assert property (timer_irq_flag && timer_irq_enable &&
		global_irq_enable && svc == SVC_IDLE && !powerdown |-> vector_req)
		else $error("enabled timer request did not vector");
	a_vec_needs_en: assert property (vector_req |-> global_irq_enable &&
		((ext_pin_irq_flag && ext_pin_irq_enable) ||
		 (timer_irq_flag && timer_irq_enable) || wake_latch))
		else $error("vector without enabled source");
	a_entry_clears_gie: assert property (vector_req && vector_ack
		|=> !global_irq_enable && svc == SVC_ACTIVE)
		else $error("entry did not clear global enable");
	a_return_sets_gie: assert property (return_from_interrupt_stb && svc == SVC_ACTIVE
		|=> global_irq_enable && svc == SVC_IDLE)
		else $error("return did not set global enable");
	a_flag_held: assert property (ext_pin_irq_flag && !wr_flag
		|=> ext_pin_irq_flag)
		else $error("pin flag dropped without a write");
	a_wake_latched: assert property (powerdown && ext_edge && ext_pin_irq_enable
		|=> wake_latch)
		else $error("wake edge not latched");
	a_restore_keep: assert property (restore_stb |=> ctx_out_valid &&
		((ctx_out.flags & FLAGS_KEEP) == ($past(ctx_in.flags) & FLAGS_KEEP)))
		else $error("restore touched timeout or power-down bit");
	a_restore_acc: assert property (save_stb ##1 !save_stb ##1 (!save_stb && restore_stb)
		|=> ctx_out.acc == $past(ctx_in.acc, 3))
		else $error("restored accumulator differs from saved");
	a_reserved_edge: assert property (ext_edge_mode == EDGE_RSVD |-> !ext_edge)
		else $error("reserved mode produced an edge");

	c_pin_vector: cover property (ext_edge ##[1:4] vector_req ##0 vector_ack);
	c_tmr_no_en: cover property (timer_ovf && !timer_irq_enable);
	c_wake_service: cover property (wake_latch && !powerdown && vector_req);
	c_save_restore: cover property (save_stb ##[1:20] restore_stb);

endmodule : eti_unit
`default_nettype wire

/* testbench/eti_core_model.sv */
// Core-side partner: takes the interrupt vector and returns from service
`timescale 1ns/100ps
`default_nettype none
module eti_core_model
	import eti_pkg::*;
(
	input  wire logic        hclk,        // Core clock
	input  wire logic        hresetn,     // Reset, active low
	input  wire logic        vector_req,  // Entry request from the unit
	input  wire logic [11:0] vector_addr, // Vector offered
	input  wire logic [3:0]  ack_delay,   // Cycles before the vector is taken
	input  wire logic        ret_en,      // Allows the return from service
	output logic             vector_ack,  // Pulse: vector taken
	output logic             return_from_interrupt_stb,    // Pulse: return from service
	output logic [7:0]       n_entry,     // Entries seen so far
	output logic [11:0]      last_addr    // Address fetched at the last entry
);
	logic [3:0] wait_cnt; // Cycles a request has waited
	logic       in_svc;   // Inside the service routine
	// ------------------------------------------------
	// Fetch side: slow or prompt acknowledge, one pulse
	// ------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vector_ack <= 1'b0;
			return_from_interrupt_stb <= 1'b0;
			n_entry <= 8'h00;
			last_addr <= 12'h000;
			wait_cnt <= 4'h0;
			in_svc <= 1'b0;
		end else begin
			vector_ack <= 1'b0;
			return_from_interrupt_stb <= 1'b0;
			// Acknowledge only while the request stands
			if (vector_req && !vector_ack && !in_svc) begin
				if (wait_cnt >= ack_delay) begin
					vector_ack <= 1'b1;
					in_svc <= 1'b1;
					n_entry <= n_entry + 8'h01;
					last_addr <= vector_addr;
					wait_cnt <= 4'h0;
				end else begin
					wait_cnt <= wait_cnt + 4'h1;
				end
			end
			// Return only when the bench allows it, so GLOBAL_IRQ_ENABLE can be seen low
			if (in_svc && ret_en && !return_from_interrupt_stb) begin
				return_from_interrupt_stb <= 1'b1;
				in_svc <= 1'b0;
			end
		end
	end
endmodule : eti_core_model
`default_nettype wire

/* testbench/edge_and_timer_interrupt_unit_tb.sv */
// Self-checking bench for the edge and timer interrupt unit
`timescale 1ns/100ps
`default_nettype none
module edge_and_timer_interrupt_unit_tb
	import eti_pkg::*;
;
	logic        hclk = 1'b0;                               // Core clock
	logic        hresetn, hsel, hwrite, hready, hresp;      // Bus control
	logic        ext_pin, timer_ovf, powerdown, wake_req;   // Pin and events
	logic        vector_req, vector_ack, return_from_interrupt_stb, irq;     // Core side
	logic        save_stb, restore_stb, ctx_out_valid;      // Context buffer
	logic        ret_en, woke;                              // Bench controls
	logic [11:0] haddr, vector_addr, last_addr;             // Addresses
	logic [1:0]  htrans;                                    // Transfer type
	logic [2:0]  hsize;                                     // Transfer size
	logic [31:0] hwdata, hrdata, rd;                        // Bus data
	logic [7:0]  n_entry, n0;                               // Entry counts
	logic [3:0]  ack_delay;                                 // Core answer delay
	eti_ctx_t    ctx_in, ctx_out, sa, sb, sc;               // Contexts
	int          n_fail = 0, n_compared = 0;                // Tallies

	eti_unit uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
		.ext_pin(ext_pin), .timer_ovf(timer_ovf), .powerdown(powerdown),
		.wake_req(wake_req), .vector_req(vector_req), .vector_ack(vector_ack),
		.vector_addr(vector_addr), .return_from_interrupt_stb(return_from_interrupt_stb), .save_stb(save_stb),
		.restore_stb(restore_stb), .ctx_in(ctx_in), .ctx_out(ctx_out),
		.ctx_out_valid(ctx_out_valid), .irq(irq));
	eti_core_model core (.hclk(hclk), .hresetn(hresetn), .vector_req(vector_req),
		.vector_addr(vector_addr), .ack_delay(ack_delay), .ret_en(ret_en),
		.vector_ack(vector_ack), .return_from_interrupt_stb(return_from_interrupt_stb), .n_entry(n_entry),
		.last_addr(last_addr));

	always #5 hclk = ~hclk;
	// Catch the one-cycle wake pulse
	always @(posedge hclk) if (wake_req === 1'b1) woke <= 1'b1;

	// --------
	// Helpers
	// --------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Single word transfer; each phase held until hready is seen high
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		haddr <= {2'h0, idx, 2'h0};
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		rd = hrdata;
		#1;
	endtask : bus
	task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 32'h0);
		chk(rd, exp);
	endtask : rdchk
	// Pin level change, random lead-in, then time for sync and flag
	task automatic pin(input logic v);
		repeat ($urandom_range(0, 3)) @(posedge hclk);
		@(posedge hclk);
		ext_pin <= v;
		repeat (8) @(posedge hclk);
	endtask : pin
	task automatic ctx_op(input eti_ctx_t c, input logic back);
		@(posedge hclk);
		ctx_in <= c;
		save_stb <= !back;
		restore_stb <= back;
		@(posedge hclk);
		save_stb <= 1'b0;
		restore_stb <= 1'b0;
		#1;
	endtask : ctx_op
	// Bounded wait for the core to take one more vector
	task automatic wait_entry(input logic [7:0] was);
		for (int i = 0; i < 40 && n_entry == was; i++) @(posedge hclk);
		#1;
	endtask : wait_entry
	// Restore keeps the live timeout and power-down bits
	function automatic eti_ctx_t exp_restore(input eti_ctx_t s, input eti_ctx_t c);
		return {s.acc, (s.flags & ~FLAGS_KEEP) | (c.flags & FLAGS_KEEP)};
	endfunction : exp_restore
	task automatic test_done;
		$display("compared %0d, wrong %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done

	// Watchdog far beyond the expected run
	initial begin
		#200000;
		n_fail++;
		test_done();
	end

	// ----------
	// Sequence
	// ----------
	initial begin
		{hresetn, hsel, hwrite, ext_pin, timer_ovf, powerdown} = 6'h0;
		{save_stb, restore_stb, ret_en, woke} = 4'h0;
		{haddr, htrans, hsize, hwdata} = 49'h0;
		ctx_in = 16'h0;
		ack_delay = 4'h0;
		void'($urandom(1940));
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		// Reset values and an unmapped place
		rdchk(EDGE_SEL_IDX, 32'h10);
		rdchk(IRQ_FLAG_IDX, 32'h0);
		rdchk(IRQ_EN_IDX, 32'h0);
		rdchk(STACK_IDX, 32'h3);
		bus(1'b1, 8'h10, 32'hFF);
		rdchk(8'h10, 32'h0);
		$display("test reset finished");
		// Every edge mode against a rising and a falling pin
		for (int m = 0; m < 4; m++) begin
			bus(1'b1, EDGE_SEL_IDX, 32'(m) << 3);
			rdchk(EDGE_SEL_IDX, 32'(m) << 3);
			pin(1'b1);
			rdchk(IRQ_FLAG_IDX, {31'h0, m[0]});
			bus(1'b1, IRQ_FLAG_IDX, 32'h0);
			pin(1'b0);
			rdchk(IRQ_FLAG_IDX, {31'h0, m[1]});
			bus(1'b1, IRQ_FLAG_IDX, 32'h0);
		end
		rdchk(INT_STAT_IDX, 32'h1);
		chk(32'(n_entry), 32'h0);
		$display("test edges finished");
		// Timer overflow, first disabled, then enabled
		n0 = n_entry;
		bus(1'b1, STACK_IDX, 32'h83);
		@(posedge hclk);
		timer_ovf <= 1'b1;
		@(posedge hclk);
		timer_ovf <= 1'b0;
		rdchk(IRQ_FLAG_IDX, 32'h10);
		chk(32'(n_entry - n0), 32'h0);
		ack_delay <= 4'($urandom_range(0, 9));
		bus(1'b1, IRQ_EN_IDX, 32'h10);
		rdchk(IRQ_EN_IDX, 32'h10);
		wait_entry(n0);
		chk(32'(n_entry - n0), 32'h1);
		chk(32'(last_addr), 32'(VEC_ADDR));
		rdchk(STACK_IDX, 32'h3);
		rdchk(IRQ_FLAG_IDX, 32'h10);
		chk(32'(irq), 32'h0);
		bus(1'b1, INT_MASK_IDX, 32'h4);
		chk(32'(irq), 32'h1);
		bus(1'b1, INT_STAT_IDX, 32'h7);
		chk(32'(irq), 32'h0);
		bus(1'b1, IRQ_FLAG_IDX, 32'h0);
		ret_en <= 1'b1;
		repeat (3) @(posedge hclk);
		rdchk(STACK_IDX, 32'h83);
		ret_en <= 1'b0;
		chk(32'(n_entry - n0), 32'h1);
		$display("test timer finished");
		// Falling edge while asleep: wake, no entry until awake
		n0 = n_entry;
		bus(1'b1, EDGE_SEL_IDX, 32'h10);
		bus(1'b1, IRQ_EN_IDX, 32'h1);
		rdchk(IRQ_EN_IDX, 32'h1);
		pin(1'b1);
		woke = 1'b0;
		powerdown <= 1'b1;
		pin(1'b0);
		chk(32'(woke), 32'h1);
		chk(32'(n_entry - n0), 32'h0);
		powerdown <= 1'b0;
		wait_entry(n0);
		chk(32'(n_entry - n0), 32'h1);
		chk(32'(last_addr), 32'(VEC_ADDR));
		$display("test wake finished");
		// Save twice, restore once: only the last save survives
		for (int i = 0; i < 4; i++) begin
			sa = 16'($urandom);
			sb = 16'($urandom);
			sc = 16'($urandom);
			ctx_op(sa, 1'b0);
			rdchk(SAVE_VIEW_IDX, {16'h0, sa});
			ctx_op(sb, 1'b0);
			ctx_op(sc, 1'b1);
			chk(32'(ctx_out_valid), 32'h1);
			chk({16'h0, ctx_out}, {16'h0, exp_restore(sb, sc)});
		end
		$display("test context finished");
		test_done();
	end
endmodule : edge_and_timer_interrupt_unit_tb
`default_nettype wire
